// ===== rtl/fpsc_pkg.sv
// package: power state encodings, capability layout and timing constants
package fpsc_pkg;
    typedef enum logic [1:0] {FPSC_D0 = 2'b00, FPSC_D1 = 2'b01, FPSC_D2 = 2'b10,
        FPSC_D3HOT = 2'b11} fpsc_pstate_e;
    localparam int FPSC_CLK_MHZ = 250;
    localparam int FPSC_D2_RECOVERY_US = 200;
    localparam int FPSC_D3_RECOVERY_MS = 10;
    localparam int FPSC_D2_RECOVERY_CYC = FPSC_D2_RECOVERY_US * FPSC_CLK_MHZ;
    localparam int FPSC_D3_RECOVERY_CYC = FPSC_D3_RECOVERY_MS * 1000 * FPSC_CLK_MHZ;
    localparam int FPSC_INT_RESET_CYC = 16;
    // capability register field positions
    localparam int FPSC_CAP_D1_BIT = 9;
    localparam int FPSC_CAP_D2_BIT = 10;
    localparam int FPSC_CAP_AUXI_LSB = 6;
    localparam int FPSC_CAP_AUXI_MSB = 8;
    // control/status field positions
    localparam int FPSC_CSR_PS_LSB = 0;
    localparam int FPSC_CSR_NOSR_BIT = 3;
    localparam int FPSC_CSR_WEN_BIT = 8;
    localparam int FPSC_CSR_WST_BIT = 15;
    localparam logic [15:0] FPSC_CSR_RESET = 16'h0000;
endpackage

// ===== rtl/fpsc_if.sv
// interface: configuration-side link between host controller and function
`timescale 1ns/1ps
`default_nettype none
interface fpsc_if;
    logic cfg_wr;
    logic [1:0] cfg_sel;
    logic [15:0] cfg_wdata;
    logic [15:0] cfg_rdata;
    logic cfg_busy;
    logic bus_rst;
    logic vcc_ok;
    modport dev (input cfg_wr, cfg_sel, cfg_wdata, bus_rst, vcc_ok,
        output cfg_rdata, cfg_busy);
    modport host (output cfg_wr, cfg_sel, cfg_wdata, bus_rst, vcc_ok,
        input cfg_rdata, cfg_busy);
endinterface
`default_nettype wire

// ===== rtl/fpsc_func.sv
// function end: power state machine, access gating and wake context
//
// Notes on behaviour
// RULE1: D0, D3hot, D3cold always present
// RULE2: D1 and D2 optional by parameter
// RULE3: D0 write from D3hot goes to D0
// RULE4: leave D3cold only via power and reset
// RULE5: reset lands in uninitialized D0
// RULE6: D1/D2: config only, wake event only
// RULE7: config space accessible in D1/D2
// RULE8: memory, mastering, interrupts only active D0
// RULE9: host waits 200 us after D2 exit
// RULE10: host waits 10 ms after D3 exit
// RULE11: D3hot still answers configuration
// RULE12: internal reset option fixed by parameter
// RULE13: no-soft-reset bit reflects that option
// RULE14: drivers off during internal reset
// RULE15: wake context kept through D3hot exit
// RULE16: power loss gives D3cold, reset reloads defaults
// RULE17: wake context kept on aux through D3cold
// RULE18: aux current in capability bits 8:6
// RULE19: D1 support same at 66 MHz
// RULE20: D2 bit reads 0 on 66 MHz bus
// RULE21: unsupported state writes are ignored
`timescale 1ns/1ps
`default_nettype none
module fpsc_func #(
    parameter bit HAS_D1 = 1'b1,
    parameter bit HAS_D2 = 1'b1,
    parameter bit NO_SOFT_RESET = 1'b0,
    parameter logic [2:0] AUX_CURRENT = 3'h1
) (
    input wire logic sys_clk,
    input wire logic rst,
    fpsc_if.dev link,
    input wire logic bus_66mhz,
    input wire logic wake_req,
    output logic mem_io_enable,
    output logic master_enable,
    output logic irq_enable,
    output logic drivers_enable,
    output logic wake_event,
    output logic initialized,
    output logic cold,
    output logic [1:0] power_state_field
);
    ////////////////////////////////////////////////////////////////////////
    logic [1:0] ps_r;
    logic init_r;
    logic cold_r;
    logic wen_r;
    logic wst_r;
    logic irst_r;
    logic [4:0] irst_cnt_r;
    logic [1:0] m66_sync_r;
    logic [1:0] wreq_sync_r;
    logic [1:0] vcc_sync_r;
    logic [1:0] brst_sync_r;
    logic we_r;

    // asynchronous pins pass two flops first
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            m66_sync_r <= 2'h0;
            wreq_sync_r <= 2'h0;
            // supply is taken as present across reset, so release does not fake a power loss
            vcc_sync_r <= 2'h3;
            brst_sync_r <= 2'h0;
        end
        else
        begin
            m66_sync_r <= {m66_sync_r[0], bus_66mhz};
            wreq_sync_r <= {wreq_sync_r[0], wake_req};
            vcc_sync_r <= {vcc_sync_r[0], link.vcc_ok};
            brst_sync_r <= {brst_sync_r[0], link.bus_rst};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    wire on_66 = m66_sync_r[1];
    wire d2_ok = HAS_D2 && !on_66; // RULE20 RULE19
    wire d1_ok = HAS_D1; // RULE2 RULE19
    wire [1:0] req_ps = link.cfg_wdata[fpsc_pkg::FPSC_CSR_PS_LSB +: 2];
    // config writes accepted in every powered state, held off during internal reset
    wire csr_wr = link.cfg_wr && (link.cfg_sel == 2'h1) && !cold_r && !irst_r; // RULE7 RULE11
    wire req_ok = (req_ps == fpsc_pkg::FPSC_D0) || (req_ps == fpsc_pkg::FPSC_D3HOT)
        || ((req_ps == fpsc_pkg::FPSC_D1) && d1_ok)
        || ((req_ps == fpsc_pkg::FPSC_D2) && d2_ok); // RULE1 RULE21
    wire ps_wr = csr_wr && req_ok;
    wire init_wr = link.cfg_wr && (link.cfg_sel == 2'h2) && !cold_r && !irst_r;
    wire leave_d3 = ps_wr && (ps_r == fpsc_pkg::FPSC_D3HOT) && (req_ps == fpsc_pkg::FPSC_D0);
    wire do_irst = leave_d3 && !NO_SOFT_RESET; // RULE12
    wire is_active = (ps_r == fpsc_pkg::FPSC_D0) && init_r && !cold_r && !irst_r;
    wire wake_src = wreq_sync_r[1] && wen_r;

    ////////////////////////////////////////////////////////////////////////
    // rst is power-on reset; the segment reset comes in on link.bus_rst. Wake enable/status
    // model the aux-powered well: they survive bus_rst and vcc loss; of the resets only rst clears them
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ps_r <= fpsc_pkg::FPSC_D0; // RULE5 RULE16
            init_r <= 1'b0; // RULE5
            cold_r <= 1'b0;
            irst_r <= 1'b0;
            irst_cnt_r <= 5'h0;
        end
        else if (!vcc_sync_r[1])
        begin
            cold_r <= 1'b1; // RULE16
            init_r <= 1'b0;
        end
        else if (cold_r || brst_sync_r[1])
        begin
            // segment reset reloads defaults; only it leaves cold once supply is back
            if (brst_sync_r[1])
            begin
                cold_r <= 1'b0; // RULE4
                ps_r <= fpsc_pkg::FPSC_D0; // RULE5 RULE16
                init_r <= 1'b0; // RULE5
                irst_r <= 1'b0;
                irst_cnt_r <= 5'h0;
            end
        end
        else if (irst_r)
        begin
            irst_cnt_r <= irst_cnt_r + 5'h1;
            if (irst_cnt_r == 5'(fpsc_pkg::FPSC_INT_RESET_CYC - 1))
                irst_r <= 1'b0;
        end
        else
        begin
            if (ps_wr)
                ps_r <= req_ps; // RULE3 RULE21
            if (do_irst)
            begin
                irst_r <= 1'b1; // RULE14
                irst_cnt_r <= 5'h0;
                init_r <= 1'b0;
            end
            else if (init_wr && ps_r == fpsc_pkg::FPSC_D0)
                init_r <= link.cfg_wdata[0];
        end
    end

    // wake context: aux powered, kept through internal reset and cold
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wen_r <= 1'b0;
            wst_r <= 1'b0;
            we_r <= 1'b0;
        end
        else
        begin
            if (csr_wr)
                wen_r <= link.cfg_wdata[fpsc_pkg::FPSC_CSR_WEN_BIT]; // RULE15 RULE17
            // set wins over write-one-to-clear
            if (wake_src)
                wst_r <= 1'b1; // RULE15 RULE17
            else if (csr_wr && link.cfg_wdata[fpsc_pkg::FPSC_CSR_WST_BIT])
                wst_r <= 1'b0;
            we_r <= wake_src && !irst_r; // RULE6
        end
    end

    ////////////////////////////////////////////////////////////////////////
    wire [15:0] cap_word = 16'h0003
        | (16'(AUX_CURRENT) << fpsc_pkg::FPSC_CAP_AUXI_LSB) // RULE18
        | (16'(d1_ok) << fpsc_pkg::FPSC_CAP_D1_BIT)
        | (16'(d2_ok) << fpsc_pkg::FPSC_CAP_D2_BIT); // RULE20
    wire [15:0] csr_word = fpsc_pkg::FPSC_CSR_RESET | 16'(ps_r)
        | (16'(NO_SOFT_RESET) << fpsc_pkg::FPSC_CSR_NOSR_BIT) // RULE13
        | (16'(wen_r) << fpsc_pkg::FPSC_CSR_WEN_BIT)
        | (16'(wst_r) << fpsc_pkg::FPSC_CSR_WST_BIT);
    wire [15:0] sel_word = (link.cfg_sel == 2'h0) ? cap_word :
        (link.cfg_sel == 2'h1) ? csr_word : 16'(init_r);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            link.cfg_rdata <= 16'h0000;
        else
            link.cfg_rdata <= (cold_r || irst_r) ? 16'h0000 : sel_word; // RULE7 RULE11
    end

    assign link.cfg_busy = cold_r || irst_r;
    assign mem_io_enable = is_active; // RULE6 RULE8
    assign master_enable = is_active; // RULE8
    assign irq_enable = is_active; // RULE8
    assign drivers_enable = !cold_r && !irst_r; // RULE14
    assign wake_event = we_r;
    assign initialized = init_r;
    assign cold = cold_r;
    assign power_state_field = ps_r;
endmodule // fpsc_func
`default_nettype wire

// ===== rtl/fpsc_host.sv
// host end: issues power state changes and enforces recovery waits
`timescale 1ns/1ps
`default_nettype none
module fpsc_host #(
    parameter int D2_WAIT = fpsc_pkg::FPSC_D2_RECOVERY_CYC,
    parameter int D3_WAIT = fpsc_pkg::FPSC_D3_RECOVERY_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    fpsc_if.host link,
    input wire logic req_valid,
    input wire logic [1:0] req_sel,
    input wire logic [15:0] req_wdata,
    input wire logic req_write,
    output logic req_ready,
    output logic [15:0] rsp_data,
    output logic rsp_valid,
    input wire logic seg_reset,
    input wire logic supply_on
);
    ////////////////////////////////////////////////////////////////////////
    logic [1:0] cur_ps_r;
    logic [21:0] wait_r;
    logic rd_pend_r;
    logic [1:0] rd_sel_r;

    wire wait_busy = (wait_r != 22'h0);
    wire go = req_valid && req_ready;
    wire [1:0] new_ps = req_wdata[fpsc_pkg::FPSC_CSR_PS_LSB +: 2];
    wire ps_write = go && req_write && (req_sel == 2'h1);
    wire to_d0 = ps_write && (new_ps == fpsc_pkg::FPSC_D0);
    wire from_d2 = to_d0 && (cur_ps_r == fpsc_pkg::FPSC_D2);
    wire from_d3 = to_d0 && (cur_ps_r == fpsc_pkg::FPSC_D3HOT);

    // no access of any kind during recovery windows
    assign req_ready = !wait_busy && !link.cfg_busy && !rd_pend_r; // RULE9 RULE10
    assign link.cfg_wr = go && req_write;
    assign link.cfg_sel = go ? req_sel : rd_sel_r;
    assign link.cfg_wdata = req_wdata;
    assign link.bus_rst = seg_reset;
    assign link.vcc_ok = supply_on;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cur_ps_r <= fpsc_pkg::FPSC_D0;
            wait_r <= 22'h0;
            rd_pend_r <= 1'b0;
            rd_sel_r <= 2'h0;
            rsp_data <= 16'h0000;
            rsp_valid <= 1'b0;
        end
        else
        begin
            rsp_valid <= rd_pend_r;
            if (rd_pend_r)
                rsp_data <= link.cfg_rdata;
            rd_pend_r <= go && !req_write;
            if (go)
                rd_sel_r <= req_sel;
            if (seg_reset)
                cur_ps_r <= fpsc_pkg::FPSC_D0;
            else if (ps_write)
                cur_ps_r <= new_ps; // RULE3
            if (from_d3)
                wait_r <= 22'(D3_WAIT); // RULE10
            else if (from_d2)
                wait_r <= 22'(D2_WAIT); // RULE9
            else if (wait_busy)
                wait_r <= wait_r - 22'h1;
        end
    end
endmodule // fpsc_host
`default_nettype wire

// ===== tb/fpsc_assertions.sv
// checker: link-level properties of the power state controller
`timescale 1ns/1ps
`default_nettype none
module fpsc_assertions #(
    parameter bit NO_SOFT_RESET = 1'b0,
    parameter logic [2:0] AUX_CURRENT = 3'h1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cfg_wr,
    input wire logic [1:0] cfg_sel,
    input wire logic [15:0] cfg_wdata,
    input wire logic [15:0] cfg_rdata,
    input wire logic cfg_busy,
    input wire logic bus_rst,
    input wire logic vcc_ok
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic d3_r;
    wire ps_wr = cfg_wr && cfg_sel == 2'h1 && !cfg_busy;
    wire rd_csr = !cfg_wr && cfg_sel == 2'h1 && !cfg_busy;
    // tracks d3hot only as far as the link shows it
    always_ff @(posedge sys_clk or posedge rst)
        if (rst) d3_r <= 1'b0;
        else if (ps_wr) d3_r <= cfg_wdata[1:0] == 2'h3;
        else if (bus_rst) d3_r <= 1'b0;
    ////////////////////////////////////////////////////////////////////////////
    sequence s_int_rst;
        cfg_busy[*8] ##1 cfg_busy[*7];
    endsequence
    sequence s_d3_exit;
        !NO_SOFT_RESET && d3_r && ps_wr && cfg_wdata[1:0] == 2'h0;
    endsequence
    a_no_wr_busy: assert property (!(cfg_wr && cfg_busy))
        else $error("write during busy");
    a_cold_busy: assert property ((!vcc_ok)[*5] |-> cfg_busy)
        else $error("no busy after supply loss");
    a_cold_stays: assert property ((!vcc_ok)[*5] ##1 (!bus_rst)[*4] |-> cfg_busy)
        else $error("left cold without segment reset");
    a_int_reset: assert property (s_d3_exit |=> s_int_rst ##[1:2] !cfg_busy)
        else $error("internal reset span wrong");
    a_cap_fields: assert property (!cfg_wr && cfg_sel == 2'h0 && !cfg_busy |=>
        cfg_rdata[8:6] == AUX_CURRENT && cfg_rdata[1:0] == 2'h3)
        else $error("capability fields wrong");
    a_nosr_bit: assert property (rd_csr |=> cfg_rdata[3] == NO_SOFT_RESET)
        else $error("no soft reset bit wrong");
    a_d3_answers: assert property (ps_wr && cfg_wdata[1:0] == 2'h3 ##1 rd_csr
        |=> cfg_rdata[1:0] == 2'h3)
        else $error("d3hot read back wrong");
    a_rst_rdata: assert property ($fell(rst) |-> cfg_rdata == 16'h0000)
        else $error("read data not cleared by reset");
endmodule // fpsc_assertions
`default_nettype wire

// ===== tb/tb_function_power_state_ctrl.sv
// testbench: host and function ends joined over the link
`timescale 1ns/1ps
`default_nettype none
module tb_function_power_state_ctrl;
    logic sys_clk, rst, req_valid, req_write, seg_reset, supply_on, bus_66mhz, wake_req;
    logic req_ready, rsp_valid, mem_io_enable, master_enable, irq_enable;
    logic drivers_enable, wake_event, initialized, cold;
    logic [1:0] req_sel, power_state_field, ps_v;
    logic [15:0] req_wdata, rsp_data, rd_v;
    logic [31:0] seed;
    int errors, tests_run, n;
    fpsc_if link();
    fpsc_host #(.D2_WAIT(20), .D3_WAIT(40)) i_fpsc_host (.sys_clk(sys_clk), .rst(rst),
        .link(link), .req_valid(req_valid), .req_sel(req_sel), .req_wdata(req_wdata),
        .req_write(req_write), .req_ready(req_ready), .rsp_data(rsp_data),
        .rsp_valid(rsp_valid), .seg_reset(seg_reset), .supply_on(supply_on));
    fpsc_func i_fpsc_func (.sys_clk(sys_clk),
        .rst(rst), .link(link), .bus_66mhz(bus_66mhz), .wake_req(wake_req),
        .mem_io_enable(mem_io_enable), .master_enable(master_enable),
        .irq_enable(irq_enable), .drivers_enable(drivers_enable), .wake_event(wake_event),
        .initialized(initialized), .cold(cold), .power_state_field(power_state_field));
    fpsc_assertions #(.NO_SOFT_RESET(1'b0), .AUX_CURRENT(3'h1)) i_fpsc_assertions (
        .sys_clk(sys_clk), .rst(rst), .cfg_wr(link.cfg_wr), .cfg_sel(link.cfg_sel),
        .cfg_wdata(link.cfg_wdata), .cfg_rdata(link.cfg_rdata), .cfg_busy(link.cfg_busy),
        .bus_rst(link.bus_rst), .vcc_ok(link.vcc_ok));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %s exp %h got %h", name, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // counts refused cycles, so a recovery wait can be measured
    task automatic wait_ready();
        n = 0;
        while (req_ready !== 1'b1 && n < 200)
        begin
            @(negedge sys_clk);
            n++;
        end
    endtask
    task automatic acc(input logic w, input logic [1:0] s, input logic [15:0] d);
        wait_ready();
        req_valid = 1'b1;
        req_write = w;
        req_sel = s;
        req_wdata = d;
        @(negedge sys_clk);
        req_valid = 1'b0;
        n = 0;
        while (!w && rsp_valid !== 1'b1 && n < 8)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (!w)
            chk("rsp valid", 16'h0001, {15'h0000, rsp_valid});
        rd_v = rsp_data;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial
    begin
        repeat (3000) @(posedge sys_clk);
        errors++;
        end_sim();
    end
    initial
    begin
        {rst, supply_on, req_valid, req_write, seg_reset, bus_66mhz, wake_req} = 7'h60;
        req_sel = 2'h0;
        req_wdata = 16'h0000;
        seed = 32'h18;
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk("start", 16'h0001, {12'h000, initialized, power_state_field, drivers_enable});
        acc(1'b0, 2'h0, 16'h0000);
        chk("cap", 16'h0643, rd_v & 16'h07c3);
        acc(1'b1, 2'h2, 16'h0001);
        chk("enables", 16'h0007, {13'h0, mem_io_enable, master_enable, irq_enable});
        for (int i = 0; i < 8; i++)
        begin
            seed = xs(seed);
            ps_v = (seed[1:0] == 2'h3) ? 2'h1 : seed[1:0];
            wake_req = seed[9];
            acc(1'b1, 2'h1, {7'h00, seed[8], 6'h00, ps_v});
            acc(1'b0, 2'h1, 16'h0000);
            chk("ps", {14'h0000, ps_v}, rd_v & 16'h0003);
            chk("mem", {15'h0000, ps_v == 2'h0}, {15'h0000, mem_io_enable});
            chk("wake", {15'h0000, seed[9] & seed[8]}, {15'h0000, wake_event});
        end
        acc(1'b1, 2'h1, 16'h0102);
        acc(1'b1, 2'h1, 16'h0100);
        wait_ready();
        chk("d2 wait", 16'h0001, {15'h0000, n >= 17 && n <= 22});
        wake_req = 1'b1;
        acc(1'b1, 2'h1, 16'h0103);
        acc(1'b0, 2'h1, 16'h0000);
        chk("d3", 16'h0103, rd_v & 16'h0103);
        chk("d3 wake", 16'h0001, {15'h0000, wake_event});
        acc(1'b1, 2'h1, 16'h0100);
        @(negedge sys_clk);
        chk("drivers", 16'h0000, {15'h0000, drivers_enable});
        wait_ready();
        chk("d3 wait", 16'h0001, {15'h0000, n >= 36 && n <= 42});
        acc(1'b0, 2'h1, 16'h0000);
        chk("d3 exit", 16'h0100, rd_v & 16'h010b);
        chk("uninit", 16'h0000, {15'h0000, initialized});
        bus_66mhz = 1'b1;
        repeat (4) @(negedge sys_clk);
        acc(1'b0, 2'h0, 16'h0000);
        chk("d2 bit", 16'h0000, rd_v & 16'h0400);
        acc(1'b1, 2'h1, 16'h0102);
        chk("refused", 16'h0000, {14'h0000, power_state_field});
        bus_66mhz = 1'b0;
        supply_on = 1'b0;
        repeat (8) @(negedge sys_clk);
        chk("cold", 16'h0001, {15'h0000, cold});
        supply_on = 1'b1;
        repeat (8) @(negedge sys_clk);
        chk("cold hold", 16'h0001, {15'h0000, cold});
        seg_reset = 1'b1;
        repeat (4) @(negedge sys_clk);
        seg_reset = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk("cold exit", 16'h0000, {12'h000, cold, initialized, power_state_field});
        acc(1'b0, 2'h1, 16'h0000);
        chk("aux ctx", 16'h0100, rd_v & 16'h0100);
        end_sim();
    end
endmodule // tb_function_power_state_ctrl
`default_nettype wire
